// [core/rcr_top.sv]
// reset cause recorder with axi4-lite register slave and event interrupt
`timescale 1ns/1ps
module rcr_top
	import rcr_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// reset sources, levels, may be asynchronous
	input  wire logic                  ext_pin_cause,
	input  wire logic                  power_on_cause,
	input  wire logic                  brownout_cause,
	input  wire logic                  first_watchdog_cause,
	input  wire logic                  software_reset_cause,
	input  wire logic                  second_watchdog_cause,
	input  wire logic                  main_osc_fail_cause,
	// axi4-lite write address
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [RCR_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	// axi4-lite write data
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [RCR_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	// axi4-lite write response
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output logic [1:0]                 s_axi_bresp,
	// axi4-lite read address
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [RCR_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	// axi4-lite read data
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [RCR_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	// level interrupt, any unmasked status bit
	output logic                       irq
);
	// ---- helper functions
	// map the event vector onto cause bit positions
	function automatic logic [31:0] evt_to_bits(input logic [RCR_NUM_EVT-1:0] ev);
		logic [31:0] b;
		b = 32'h00000000;
		b[RCR_BIT_OSC]   = ev[RCR_EV_OSC];
		b[RCR_BIT_DOG_B] = ev[RCR_EV_DOG_B];
		b[RCR_BIT_SOFT]  = ev[RCR_EV_SOFT];
		b[RCR_BIT_DOG_A] = ev[RCR_EV_DOG_A];
		b[RCR_BIT_BROWN] = ev[RCR_EV_BROWN];
		b[RCR_BIT_POR]  = ev[RCR_EV_POR];
		b[RCR_BIT_EXT]  = ev[RCR_EV_EXT];
		return b;
	endfunction : evt_to_bits

	// byte strobes widened to a bit mask
	function automatic logic [31:0] strb_to_mask(input logic [3:0] s);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = 0; i < 4; i++) begin
			m[8*i +: 8] = {8{s[i]}};
		end
		return m;
	endfunction : strb_to_mask

	// word-aligned view of a byte address
	function automatic logic [11:0] word_addr(input logic [RCR_ADDR_W-1:0] a);
		return {a[RCR_ADDR_W-1:2], 2'h0};
	endfunction : word_addr

	// true for any mapped offset
	function automatic logic is_mapped(input logic [11:0] a);
		return (a == RCR_OFF_CAUSE) || (a == RCR_OFF_STAT) || (a == RCR_OFF_MASK);
	endfunction : is_mapped

	// ---- synchronise the reset sources
	logic [RCR_NUM_EVT-1:0] ev_raw;   // raw event levels
	logic [RCR_NUM_EVT-1:0] ev_s;     // synchronised event levels
	logic [RCR_NUM_EVT-1:0] ev_prev_q; // previous synchronised levels
	logic [RCR_NUM_EVT-1:0] ev_prev_d;
	logic [31:0]            set_lvl;  // cause bits asserted now
	logic [31:0]            set_rise; // cause bits newly asserted

	always_comb begin
		ev_raw               = '0;
		ev_raw[RCR_EV_EXT]   = ext_pin_cause;
		ev_raw[RCR_EV_POR]   = power_on_cause;
		ev_raw[RCR_EV_BROWN] = brownout_cause;
		ev_raw[RCR_EV_DOG_A] = first_watchdog_cause;
		ev_raw[RCR_EV_SOFT]  = software_reset_cause;
		ev_raw[RCR_EV_DOG_B] = second_watchdog_cause;
		ev_raw[RCR_EV_OSC]   = main_osc_fail_cause;
	end

	rcr_sync #(
		.WIDTH  (RCR_NUM_EVT),
		.STAGES (RCR_SYNC_STAGES)
	) u_sync (
		.aclk     (aclk),
		.async_in (ev_raw),
		.sync_out (ev_s)
	);

	// edge detect on the synchronised side only
	always_comb begin
		ev_prev_d = ev_s;
		set_lvl   = evt_to_bits(ev_s);
		set_rise  = evt_to_bits(ev_s & ~ev_prev_q);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_prev_q <= '0;
		end else begin
			ev_prev_q <= ev_prev_d;
		end
	end

	// ---- axi4-lite write channels
	logic                  aw_held_q, aw_held_d;  // address taken, not yet used
	logic [11:0]           aw_addr_q, aw_addr_d;  // held word address
	logic                  w_held_q, w_held_d;    // data taken, not yet used
	logic [31:0]           w_data_q, w_data_d;    // held write data
	logic [3:0]            w_strb_q, w_strb_d;    // held byte strobes
	logic                  bvalid_q, bvalid_d;    // write response pending
	logic [1:0]            bresp_q, bresp_d;      // write response code
	logic                  wr_fire;               // write applied this cycle
	logic                  wr_cause;              // write hits the cause record
	logic                  wr_mask;               // write hits the mask

	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready  = !w_held_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// take address and data in either order, apply once both are held
	always_comb begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d  = w_held_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		wr_fire   = aw_held_q && w_held_q && !bvalid_q;
		wr_cause  = wr_fire && (aw_addr_q == RCR_OFF_CAUSE);
		wr_mask   = wr_fire && (aw_addr_q == RCR_OFF_MASK);
		if (s_axi_awvalid && !aw_held_q) begin  // address handshake
			aw_held_d = 1'b1;
			aw_addr_d = word_addr(s_axi_awaddr);
		end
		if (s_axi_wvalid && !w_held_q) begin    // data handshake
			w_held_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (wr_fire) begin                      // apply and answer
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = is_mapped(aw_addr_q) ? RCR_RESP_OKAY : RCR_RESP_DEC;
		end else if (bvalid_q && s_axi_bready) begin  // response taken
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RCR_RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q  <= w_held_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// ---- reset cause record, deliberately outside the system reset
	logic [31:0] cause_q, cause_d;  // reset_cause_record contents

	always_comb begin
		cause_d = cause_q;
		if (wr_cause) begin
			// zero in a strobed lane clears, one
			cause_d = cause_q & (w_data_q | ~strb_to_mask(w_strb_q));
		end
		cause_d = (cause_d | set_lvl) & RCR_CAUSE_MASK;  // set wins
		if (ev_s[RCR_EV_POR]) begin
			cause_d = RCR_POR_ONLY;  // power-on wipes the others
		end
	end

	// no aresetn here so causes persist across reset sequences
	always_ff @(posedge aclk) begin
		cause_q <= cause_d;
	end

	// ---- interrupt status and mask
	logic [31:0] stat_q, stat_d;  // sticky event bits
	logic [31:0] mask_q, mask_d;  // interrupt enables
	logic        rd_fire;         // read address taken
	logic [11:0] rd_addr;         // word address of the read

	always_comb begin
		stat_d = stat_q;
		mask_d = mask_q;
		if (rd_fire && (rd_addr == RCR_OFF_STAT)) begin
			stat_d = 32'h00000000;  // read clears
		end
		stat_d = stat_d | set_rise;  // new event beats read clear
		if (wr_mask) begin
			mask_d = ((mask_q & ~strb_to_mask(w_strb_q)) |
				(w_data_q & strb_to_mask(w_strb_q))) & RCR_CAUSE_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= RCR_STAT_RST;
			mask_q <= RCR_MASK_RST;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
		end
	end

	// level output, high while any unmasked event is pending
	logic irq_q, irq_d;
	always_comb begin
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end
	assign irq = irq_q;

	// ---- axi4-lite read channels
	logic        rvalid_q, rvalid_d;  // read data pending
	logic [31:0] rdata_q, rdata_d;    // registered read data
	logic [1:0]  rresp_q, rresp_d;    // read response code

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_fire       = s_axi_arvalid && !rvalid_q;
	assign rd_addr       = word_addr(s_axi_araddr);

	// address decode and capture of read data
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d  = RCR_RESP_OKAY;
			if (rd_addr == RCR_OFF_CAUSE) begin
				rdata_d = cause_q & RCR_CAUSE_MASK;  // reserved read zero
			end else if (rd_addr == RCR_OFF_STAT) begin
				rdata_d = stat_q;
			end else if (rd_addr == RCR_OFF_MASK) begin
				rdata_d = mask_q;
			end else begin
				rdata_d = 32'h00000000;  // unmapped
				rresp_d = RCR_RESP_DEC;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= RCR_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end
endmodule : rcr_top

// [core/rcr_pkg.sv]
// constants, register map and field layout of the reset cause recorder
// Functional notes
// - cause bits survive later resets, accumulating
// - power-on leaves only the power-on bit set
// - oscillator validation failure sets bit 16
// - second watchdog timeout sets bit 5
// - software reset request sets bit 4
// - first watchdog timeout sets bit 3
// - brown-out sets bit 2
// - power-on sets bit 1
// - external reset pin sets bit 0
// - writing zero to a cause bit clears it
// - bits 31:17 and 15:6 read zero, ignore writes
package rcr_pkg;
	localparam int          RCR_ADDR_W     = 12;             // byte address width
	localparam int          RCR_DATA_W     = 32;             // bus data width
	localparam int          RCR_NUM_EVT    = 7;              // number of cause inputs
	// register byte offsets
	localparam logic [11:0] RCR_OFF_CAUSE  = 12'h05C;        // reset_cause_record
	localparam logic [11:0] RCR_OFF_STAT   = 12'h100;        // event status, read clears
	localparam logic [11:0] RCR_OFF_MASK   = 12'h104;        // event interrupt mask
	// cause bit positions inside reset_cause_record
	localparam int          RCR_BIT_EXT    = 0;              // external reset pin
	localparam int          RCR_BIT_POR    = 1;              // power-on
	localparam int          RCR_BIT_BROWN  = 2;              // brownout_cause
	localparam int          RCR_BIT_DOG_A  = 3;              // first_watchdog_cause
	localparam int          RCR_BIT_SOFT   = 4;              // software_reset_cause
	localparam int          RCR_BIT_DOG_B  = 5;              // second_watchdog_cause
	localparam int          RCR_BIT_OSC    = 16;             // main_osc_fail_cause
	// event input index in the cause input vector
	localparam int          RCR_EV_EXT     = 0;
	localparam int          RCR_EV_POR     = 1;
	localparam int          RCR_EV_BROWN   = 2;
	localparam int          RCR_EV_DOG_A   = 3;
	localparam int          RCR_EV_SOFT    = 4;
	localparam int          RCR_EV_DOG_B   = 5;
	localparam int          RCR_EV_OSC     = 6;
	// implemented bits, all others are reserved and read zero
	localparam logic [31:0] RCR_CAUSE_MASK = 32'h0001003F;
	localparam logic [31:0] RCR_POR_ONLY   = 32'h00000002;
	// values after reset
	localparam logic [31:0] RCR_STAT_RST   = 32'h00000000;
	localparam logic [31:0] RCR_MASK_RST   = 32'h00000000;
	localparam int          RCR_SYNC_STAGES = 2;             // synchroniser depth
	// bus response codes
	localparam logic [1:0]  RCR_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RCR_RESP_DEC   = 2'h3;
endpackage : rcr_pkg

// [core/rcr_sync.sv]
// multi-bit level synchroniser, one chain of flops per bit
`timescale 1ns/1ps
module rcr_sync
	import rcr_pkg::*;
#(
	parameter int WIDTH  = RCR_NUM_EVT,
	parameter int STAGES = RCR_SYNC_STAGES
) (
	input  wire logic             aclk,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	// refuse chains too short to resolve metastability
	if (STAGES < 2) begin : g_bad_stages
		$error("rcr_sync needs at least two stages");
	end

	logic [WIDTH-1:0] chain_q [STAGES];  // flop chain, stage 0 faces the pin
	logic [WIDTH-1:0] chain_d [STAGES];  // next value of each stage

	// each stage takes the one before it, nothing else reads stage 0
	always_comb begin
		chain_d[0] = async_in;
		for (int i = 1; i < STAGES; i++) begin
			chain_d[i] = chain_q[i-1];
		end
	end

	// no reset: events during system reset must still get through
	always_ff @(posedge aclk) begin
		for (int i = 0; i < STAGES; i++) begin
			chain_q[i] <= chain_d[i];
		end
	end

	assign sync_out = chain_q[STAGES-1];  // registered output
endmodule : rcr_sync

// [verif/rcr_checker.sv]
// bus and cause record assertions for the reset cause recorder
`timescale 1ns/1ps
module rcr_checker
	import rcr_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        power_on_cause,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        irq
);
	logic [11:0] ar_q;  // address of the read in flight
	logic [11:0] aw_q;  // address of the write in flight
	logic [3:0]  pon_q; // cycles power-on held, saturating
	logic        ar_map, aw_map; // address hits a register
	assign ar_map = ar_q inside {RCR_OFF_CAUSE, RCR_OFF_STAT, RCR_OFF_MASK};
	assign aw_map = aw_q inside {RCR_OFF_CAUSE, RCR_OFF_STAT, RCR_OFF_MASK};
	// capture addresses at handshakes, count power-on length
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
		if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
		pon_q <= !power_on_cause ? 4'h0 : (pon_q == 4'hF ? pon_q : pon_q + 4'h1);
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped early");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rd_decode: assert property ($rose(s_axi_rvalid) && !ar_map |-> s_axi_rdata == 32'h0
		&& s_axi_rresp == RCR_RESP_DEC) else $error("unmapped read not refused");
	a_wr_decode: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
		(aw_map ? RCR_RESP_OKAY : RCR_RESP_DEC)) else $error("write response code wrong");
	a_resv_zero: assert property (s_axi_rvalid && ar_q == RCR_OFF_CAUSE |->
		(s_axi_rdata & ~RCR_CAUSE_MASK) == 32'h0) else $error("reserved bits not zero");
	a_pon_only: assert property ($rose(s_axi_rvalid) && ar_q == RCR_OFF_CAUSE
		&& pon_q >= 4'h6 |-> s_axi_rdata == RCR_POR_ONLY) else $error("power-on left bits");
	a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid
		&& !s_axi_rvalid && !irq) else $error("outputs busy in reset");
	c_irq: cover property ($rose(irq));
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_refused: cover property ($rose(s_axi_rvalid) && !ar_map);
endmodule : rcr_checker

bind rcr_top rcr_checker u_chk (.aclk(aclk), .aresetn(aresetn), .power_on_cause(power_on_cause),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .irq(irq));

// [verif/rcr_src_model.sv]
// on-chip reset sources: each request gives one held reset pulse
`timescale 1ns/1ps
module rcr_src_model
	import rcr_pkg::*;
#(
	parameter int HOLD = 12 // pulse lasts HOLD+1 cycles
) (
	input  wire logic                   aclk,
	input  wire logic [RCR_NUM_EVT-1:0] fire,
	output logic      [RCR_NUM_EVT-1:0] cause
);
	logic [RCR_NUM_EVT-1:0] act_q; // sources now driving reset
	int                     cnt_q; // cycles of pulse left
	initial begin
		act_q = '0;
		cnt_q = 0;
	end
	// latch a request, hold it, then release to idle low
	always @(posedge aclk) begin
		if (|fire) begin
			act_q <= fire;
			cnt_q <= HOLD;
		end else if (cnt_q > 0) cnt_q <= cnt_q - 1;
		else act_q <= '0;
	end
	assign cause = act_q;
endmodule : rcr_src_model

// [verif/rcr_top_tb.sv]
// self-checking bench of the reset cause recorder over axi4-lite
`timescale 1ns/1ps
module rcr_top_tb
	import rcr_pkg::*;
;
	logic        aclk = 0, aresetn = 0;            // clock, reset
	logic [6:0]  fire = '0;                        // requests to the sources
	wire  [6:0]  cause;                            // source levels
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, exp_q;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          n_mismatch = 0, n_tests = 0, k;
	int          bit_pos [7] = '{0, 1, 2, 3, 4, 5, 16}; // record bit of each source
	always #2.5 aclk = ~aclk;
	rcr_src_model #(.HOLD(12)) u_src (.aclk(aclk), .fire(fire), .cause(cause));
	rcr_top dut (.aclk(aclk), .aresetn(aresetn), .ext_pin_cause(cause[0]),
		.power_on_cause(cause[1]), .brownout_cause(cause[2]), .first_watchdog_cause(cause[3]),
		.software_reset_cause(cause[4]), .second_watchdog_cause(cause[5]),
		.main_osc_fail_cause(cause[6]), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.irq(irq));
	// verdict and end of run
	task conclude;
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	// one comparison, mismatch printed at once
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// a wait ran out
	task automatic tmo;
		n_mismatch++;
		$display("[FAIL] bus wait expected answer seen none");
		conclude();
	endtask : tmo
	// write one word, both channels offered together
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_t, w_t, b_t;
		logic [1:0] rs;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b_t = 0;
		for (int i = 0; i < 40 && !b_t; i++) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (!b_t) tmo();
		chk("bresp", er, rs);
	endtask : axi_wr
	// read one word and compare data and response
	task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ar_t, r_t;
		logic [31:0] dt;
		logic [1:0] rs;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r_t = 0;
		for (int i = 0; i < 40 && !r_t; i++) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			dt = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ar_t) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (!r_t) tmo();
		chk("rdata", e, dt);
		chk("rresp", er, rs);
	endtask : axi_rd
	// one reset pulse from source j, then w cycles
	task automatic ev(input int j, input int w);
		@(posedge aclk);
		fire <= 7'h01 << j;
		@(posedge aclk);
		fire <= '0;
		repeat (w) @(posedge aclk);
	endtask : ev
	// whole run limit
	initial begin
		repeat (20000) @(posedge aclk);
		tmo();
	end
	// main sequence
	initial begin
		ev(1, 18);
		aresetn <= 1'b1;
		axi_rd(RCR_OFF_CAUSE, RCR_POR_ONLY, RCR_RESP_OKAY);
		axi_wr(RCR_OFF_CAUSE, 32'hFFFFFFFF, RCR_RESP_OKAY);
		axi_rd(RCR_OFF_CAUSE, RCR_POR_ONLY, RCR_RESP_OKAY);
		axi_wr(RCR_OFF_CAUSE, 32'h00000000, RCR_RESP_OKAY);
		axi_rd(RCR_OFF_CAUSE, 32'h00000000, RCR_RESP_OKAY);
		exp_q = '0;
		for (k = 0; k < 7; k++) if (k != 1) begin
			ev(k, 20);
			exp_q = exp_q | (32'h1 << bit_pos[k]);
			aresetn <= 1'b0;
			repeat (3) @(posedge aclk);
			aresetn <= 1'b1;
			axi_rd(RCR_OFF_CAUSE, exp_q, RCR_RESP_OKAY);
		end
		ev(1, 8);
		axi_rd(RCR_OFF_CAUSE, RCR_POR_ONLY, RCR_RESP_OKAY);
		repeat (12) @(posedge aclk);
		axi_wr(RCR_OFF_CAUSE, 32'h00000000, RCR_RESP_OKAY);
		// clear lands on the last synchronised cycle of the pulse
		ev(0, 12);
		axi_wr(RCR_OFF_CAUSE, 32'h00000000, RCR_RESP_OKAY);
		repeat (16) @(posedge aclk);
		axi_rd(RCR_OFF_CAUSE, 32'h00000001, RCR_RESP_OKAY);
		axi_rd(12'h200, 32'h00000000, RCR_RESP_DEC);
		axi_wr(12'h200, 32'hFFFFFFFF, RCR_RESP_DEC);
		axi_wr(RCR_OFF_MASK, 32'hFFFFFFFF, RCR_RESP_OKAY);
		axi_rd(RCR_OFF_MASK, RCR_CAUSE_MASK, RCR_RESP_OKAY);
		axi_wr(RCR_OFF_MASK, 32'h00000001, RCR_RESP_OKAY);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axi_wr(RCR_OFF_MASK, 32'h00000001, RCR_RESP_OKAY);
		ev(0, 20);
		@(negedge aclk);
		chk("irq", 32'h1, irq);
		axi_rd(RCR_OFF_STAT, 32'h00000001, RCR_RESP_OKAY);
		@(negedge aclk);
		chk("irq", 32'h0, irq);
		ev(2, 20);
		@(negedge aclk);
		chk("irq", 32'h0, irq);
		axi_rd(RCR_OFF_STAT, 32'h00000004, RCR_RESP_OKAY);
		conclude();
	end
endmodule : rcr_top_tb
